// ---- design/sfifo_defines.svh ----
// Named constants for the synchronous parallel FIFO port, its clocking and its timing.
// Assumes inclusion by bare name from the package and from both port ends.
`ifndef SFIFO_DEFINES_SVH
`define SFIFO_DEFINES_SVH

// System clock and the documented interface clock rate.
`define SYS_CLK_HZ      100000000
`define IFACE_CLK_HZ    60000000
// A 60 MHz clock cannot be divided out of 100 MHz, so the divider half period is a parameter.
`define IFACE_HALF_CLKS (`SYS_CLK_HZ / (2 * `IFACE_CLK_HZ))
`define LINK_HALF_DFLT  4
// Divider counter width.
`define DIV_W           8
// Data width of the port.
`define BYTE_W          8
// Level of the data wires when nobody drives them (weak pull-up).
`define IDLE_BYTE       8'hff
// Output enable must lead the read strobe by this many interface clock periods.
`define TURN_PERIODS    1
// Reset value of the active-low pins, and zero values for the divider count and for a byte.
`define PIN_OFF_N       1'b1
`define DIV_ZERO        8'h00
`define BYTE_ZERO       8'h00

`endif

// ---- design/sfifo_pkg.sv ----
// Types shared by both ends of the synchronous parallel FIFO port.
// Assumes sfifo_defines.svh is on the include path.
`include "sfifo_defines.svh"

package sfifo_pkg;

  typedef logic [`BYTE_W-1:0] byte_t;
  typedef logic [`DIV_W-1:0]  div_t;

  // Host end sequencer states, one-hot.
  typedef enum logic [3:0] {
    H_IDLE  = 4'b0001,
    H_TURN  = 4'b0010,
    H_READ  = 4'b0100,
    H_WRITE = 4'b1000
  } host_state_t;

  // Whole state of the device end.
  typedef struct packed {
    div_t  div_cnt;
    logic  iclk;
    logic  oe_s1, oe_s2, rd_s1, rd_s2, wr_s1, wr_s2;
    logic  fw_s1, fw_s2, fw_s3;
    byte_t din_s1, din_s2;
    byte_t cur;
    logic  cur_valid;
    logic  rx_ready;
    logic  rx_avail_n;
    byte_t dout;
    logic  dout_oe;
    logic  tx_space_n;
    logic  tx_valid;
    byte_t tx_data;
    logic  sync_on;
    logic  chan_b;
    logic  resume;
    logic  flush_pend;
    logic  pwr_n;
  } dev_state_t;

  // State of the host end, apart from the two suspend flag synchroniser flip-flops.
  typedef struct packed {
    logic        clk_s1, clk_s2, clk_s3;
    logic        rxf_s1, rxf_s2, rxf_s3;
    logic        txe_s1, txe_s2, txe_s3;
    byte_t       din_s1, din_s2, din_s3;
    host_state_t state;
    logic        rd_n, wr_n, oe_n, flush_n;
    byte_t       dout;
    logic        dout_oe;
    byte_t       hold;
    logic        hold_valid;
    logic        wr_ready;
    logic        rd_valid;
    byte_t       rd_data;
    logic        fl_pend;
  } host_state_s_t;

endpackage : sfifo_pkg

// ---- design/sfifo_if.sv ----
// Pin-level link between the FIFO device end and the external logic end.
// Assumes the testbench instantiates it and connects both ends through the modports.
`timescale 1ns/10ps
`include "sfifo_defines.svh"

interface sfifo_if;
  logic                interface_clock;
  logic                rx_avail_n;
  logic                tx_space_n;
  logic                rd_n;
  logic                wr_n;
  logic                oe_n;
  logic                flush_wake_n;
  logic                suspended_flag_n;
  logic [`BYTE_W-1:0]  dev_data_o;
  logic                dev_data_oe;
  logic [`BYTE_W-1:0]  host_data_o;
  logic                host_data_oe;
  logic [`BYTE_W-1:0]  fifo_data_bus;

  // Resolved data wires; an undriven bus floats to the pull-up level.
  assign fifo_data_bus = dev_data_oe ? dev_data_o : (host_data_oe ? host_data_o : `IDLE_BYTE);

  modport dev_mp (
    output interface_clock, rx_avail_n, tx_space_n, suspended_flag_n, dev_data_o, dev_data_oe,
    input  rd_n, wr_n, oe_n, flush_wake_n, fifo_data_bus
  );

  modport host_mp (
    input  interface_clock, rx_avail_n, tx_space_n, suspended_flag_n, fifo_data_bus,
    output rd_n, wr_n, oe_n, flush_wake_n, host_data_o, host_data_oe
  );
endinterface : sfifo_if

// ---- design/sfifo_device.sv ----
// Device end of the synchronous parallel FIFO port: makes the interface clock, moves
// receive bytes out to the external logic and transmit bytes in from it.
// Assumes the USB side offers receive bytes first-word-fall-through and takes transmit bytes
// whenever tx_ready was high two cycles before the tx_valid pulse.
//
// Function
// - Only first channel syncs; second channel unavailable.
// - Stored config plus mode command enters mode.
// - Device drives continuous interface clock.
// - All transfers on interface clock rising edge.
// - Data bus input unless output enable low.
// - Receive flag high when empty, low otherwise.
// - Byte out each edge flag and read low.
// - Output enable leads read strobe one period.
// - Output enable low drives current receive byte.
// - Read held low fetches next byte each edge.
// - Transmit flag high when full, low otherwise.
// - Byte in each edge flag and write low.
// - Write held low captures bus each edge.
// - Suspended wake strobe requests bus resume.
// - Normal strobe flushes transmit data next bulk-IN.
// - Power flag high suspended or unconfigured.
`timescale 1ns/10ps
`include "sfifo_defines.svh"

module sfifo_device #(
  parameter int HALF_CYCLES = `LINK_HALF_DFLT
) (
  input  wire logic            clk,
  input  wire logic            rst,
  sfifo_if.dev_mp              link,
  input  wire logic            cfg_fifo_mode,
  input  wire logic            mode_select,
  input  wire logic            remote_wake_en,
  input  wire logic            usb_suspended,
  input  wire logic            usb_configured,
  input  wire logic            bulk_in_req,
  input  wire sfifo_pkg::byte_t rx_data,
  input  wire logic            rx_valid,
  output logic                 rx_ready,
  output sfifo_pkg::byte_t     tx_data,
  output logic                 tx_valid,
  input  wire logic            tx_ready,
  output logic                 sync_active,
  output logic                 chan_b_avail,
  output logic                 resume_req,
  output logic                 flush_pending
);
  import sfifo_pkg::*;

  dev_state_t st;
  dev_state_t nxt;
  logic       rise;
  logic       rd_xfer;
  logic       wr_xfer;
  logic       strobe;

  // Next-state logic for the whole device end.
  always_comb begin
    nxt     = st;
    rise    = 1'b0;
    rd_xfer = 1'b0;
    wr_xfer = 1'b0;

    // Every pin from the external logic passes two flip-flops before use.
    nxt.oe_s1  = link.oe_n;
    nxt.oe_s2  = st.oe_s1;
    nxt.rd_s1  = link.rd_n;
    nxt.rd_s2  = st.rd_s1;
    nxt.wr_s1  = link.wr_n;
    nxt.wr_s2  = st.wr_s1;
    nxt.fw_s1  = link.flush_wake_n;
    nxt.fw_s2  = st.fw_s1;
    nxt.fw_s3  = st.fw_s2;
    nxt.din_s1 = link.fifo_data_bus;
    nxt.din_s2 = st.din_s1;

    // The interface clock runs from reset onward, whatever the mode, so that the
    // external logic always has a clock to work from.
    if (st.div_cnt == div_t'(HALF_CYCLES - 1)) begin
      nxt.div_cnt = `DIV_ZERO;
      nxt.iclk    = !st.iclk;
      rise        = !st.iclk;
    end else begin
      nxt.div_cnt = div_t'(st.div_cnt + 1'b1);
    end

    // Synchronous mode needs the stored selection and then the mode command; losing
    // the stored selection drops back out of it.
    if (!cfg_fifo_mode) begin
      nxt.sync_on = 1'b0;
    end else if (mode_select) begin
      nxt.sync_on = 1'b1;
    end
    // The second channel has no buffering left while this port owns it all.
    nxt.chan_b = !nxt.sync_on;

    // One-cycle pulses default low.
    nxt.tx_valid = 1'b0;
    nxt.resume   = 1'b0;

    // Refill the current receive byte from the USB side when it is empty.
    if (st.rx_ready && rx_valid) begin
      nxt.cur       = rx_data;
      nxt.cur_valid = 1'b1;
    end

    // A receive byte leaves on a rising edge with flag and read strobe both low.
    // The decision uses the flag as it stood before the edge, which is what the
    // external logic also sees.
    if (rise && st.sync_on && !st.rx_avail_n && !st.rd_s2) begin
      rd_xfer       = 1'b1;
      nxt.cur_valid = 1'b0;
    end

    // With the strobe still low the next byte is fetched right away, so a held
    // strobe keeps taking a byte per edge as long as the USB side keeps up.
    nxt.rx_ready   = !nxt.cur_valid && nxt.sync_on;
    nxt.rx_avail_n = !(nxt.cur_valid && nxt.sync_on);

    // The data wires stay an input unless the output enable is low.
    nxt.dout    = nxt.cur;
    nxt.dout_oe = st.sync_on && !st.oe_s2;

    // A transmit byte is captured on a rising edge with flag and write strobe low.
    if (rise && st.sync_on && !st.tx_space_n && !st.wr_s2) begin
      wr_xfer      = 1'b1;
      nxt.tx_valid = 1'b1;
      nxt.tx_data  = st.din_s2;
    end
    // Room on the USB side opens the transmit flag.
    nxt.tx_space_n = !(tx_ready && nxt.sync_on);

    // The send-immediate strobe is taken on its falling edge after synchronising.
    strobe = st.fw_s3 && !st.fw_s2;
    if (bulk_in_req) begin
      nxt.flush_pend = 1'b0;
    end
    // A strobe in the same cycle as the bulk-IN request wins and stays pending.
    if (strobe && st.pwr_n && usb_suspended && remote_wake_en) begin
      nxt.resume = 1'b1;
    end else if (strobe && !st.pwr_n) begin
      nxt.flush_pend = 1'b1;
    end

    // Power flag follows the USB link state.
    nxt.pwr_n = usb_suspended || !usb_configured;
  end

  // The whole state registers here.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st            <= '0;
      st.oe_s1      <= `PIN_OFF_N;
      st.oe_s2      <= `PIN_OFF_N;
      st.rd_s1      <= `PIN_OFF_N;
      st.rd_s2      <= `PIN_OFF_N;
      st.wr_s1      <= `PIN_OFF_N;
      st.wr_s2      <= `PIN_OFF_N;
      st.fw_s1      <= `PIN_OFF_N;
      st.fw_s2      <= `PIN_OFF_N;
      st.fw_s3      <= `PIN_OFF_N;
      st.rx_avail_n <= `PIN_OFF_N;
      st.tx_space_n <= `PIN_OFF_N;
      st.chan_b     <= 1'b1;
      st.pwr_n      <= `PIN_OFF_N;
    end else begin
      st <= nxt;
    end
  end

  // Pins and user outputs come straight from the state flip-flops.
  assign link.interface_clock  = st.iclk;
  assign link.rx_avail_n       = st.rx_avail_n;
  assign link.tx_space_n       = st.tx_space_n;
  assign link.suspended_flag_n = st.pwr_n;
  assign link.dev_data_o       = st.dout;
  assign link.dev_data_oe      = st.dout_oe;

  // User side of the receive and transmit paths and the mode status.
  assign rx_ready      = st.rx_ready;
  assign tx_data       = st.tx_data;
  assign tx_valid      = st.tx_valid;
  assign sync_active   = st.sync_on;
  assign chan_b_avail  = st.chan_b;
  assign resume_req    = st.resume;
  assign flush_pending = st.flush_pend;

endmodule : sfifo_device

// ---- design/sfifo_host.sv ----
// External logic end of the synchronous parallel FIFO port: reads and writes bytes
// timed by the interface clock that the device drives.
// Assumes the device's divider half period is at least four system clocks, so that the
// synchronised view settles between interface clock edges.
`timescale 1ns/10ps
`include "sfifo_defines.svh"

module sfifo_host (
  input  wire logic             clk,
  input  wire logic             rst,
  sfifo_if.host_mp              link,
  input  wire logic             rd_want,
  output sfifo_pkg::byte_t      rd_data,
  output logic                  rd_valid,
  input  wire sfifo_pkg::byte_t wr_data,
  input  wire logic             wr_valid,
  output logic                  wr_ready,
  input  wire logic             flush_req,
  output logic                  dev_suspended
);
  import sfifo_pkg::*;

  host_state_s_t st;
  host_state_s_t nxt;
  logic          rise;
  logic          sus_s1;
  logic          sus_s2;

  // Next-state logic; pins only change in the cycle after a detected rising edge.
  always_comb begin
    nxt        = st;
    nxt.clk_s1 = link.interface_clock;
    nxt.clk_s2 = st.clk_s1;
    nxt.clk_s3 = st.clk_s2;
    nxt.rxf_s1 = link.rx_avail_n;
    nxt.rxf_s2 = st.rxf_s1;
    nxt.rxf_s3 = st.rxf_s2;
    nxt.txe_s1 = link.tx_space_n;
    nxt.txe_s2 = st.txe_s1;
    nxt.txe_s3 = st.txe_s2;
    nxt.din_s1 = link.fifo_data_bus;
    nxt.din_s2 = st.din_s1;
    nxt.din_s3 = st.din_s2;
    nxt.rd_valid = 1'b0;
    // The third stage holds the view from just before the edge, which the device used.
    rise = st.clk_s2 && !st.clk_s3;

    // One-byte hold register decouples the user from the link timing.
    if (st.wr_ready && wr_valid) begin
      nxt.hold       = wr_data;
      nxt.hold_valid = 1'b1;
    end

    if (rise) begin
      nxt.flush_n = !st.fl_pend;
      nxt.fl_pend = 1'b0;
      unique case (st.state)
        H_IDLE: begin
          if (rd_want && !st.rxf_s3) begin
            nxt.oe_n  = 1'b0;
            nxt.state = H_TURN;
          end else if (st.hold_valid && !st.txe_s3) begin
            nxt.dout       = st.hold;
            nxt.dout_oe    = 1'b1;
            nxt.wr_n       = 1'b0;
            nxt.hold_valid = 1'b0;
            nxt.state      = H_WRITE;
          end
        end
        H_TURN: begin
          // The bus has had one full period to turn round.
          nxt.rd_n  = 1'b0;
          nxt.state = H_READ;
        end
        H_READ: begin
          if (!st.rd_n && !st.rxf_s3) begin
            nxt.rd_valid = 1'b1;
            nxt.rd_data  = st.din_s3;
          end
          if (!rd_want || st.rxf_s3) begin
            nxt.rd_n  = 1'b1;
            nxt.oe_n  = 1'b1;
            nxt.state = H_IDLE;
          end
        end
        H_WRITE: begin
          // A high flag means the byte was not taken; keep it on the bus.
          if (!st.txe_s3 && st.hold_valid) begin
            nxt.dout       = st.hold;
            nxt.hold_valid = 1'b0;
          end else if (!st.txe_s3) begin
            nxt.wr_n    = 1'b1;
            nxt.dout_oe = 1'b0;
            nxt.state   = H_IDLE;
          end
        end
      endcase
    end
    // A request in the edge cycle is kept for the next period.
    if (flush_req) begin
      nxt.fl_pend = 1'b1;
    end
    nxt.wr_ready = !nxt.hold_valid;
  end

  // Whole state register.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st         <= '0;
      st.state   <= H_IDLE;
      st.rxf_s1  <= `PIN_OFF_N;
      st.rxf_s2  <= `PIN_OFF_N;
      st.rxf_s3  <= `PIN_OFF_N;
      st.txe_s1  <= `PIN_OFF_N;
      st.txe_s2  <= `PIN_OFF_N;
      st.txe_s3  <= `PIN_OFF_N;
      st.rd_n    <= `PIN_OFF_N;
      st.wr_n    <= `PIN_OFF_N;
      st.oe_n    <= `PIN_OFF_N;
      st.flush_n <= `PIN_OFF_N;
      sus_s1     <= `PIN_OFF_N;
      sus_s2     <= `PIN_OFF_N;
    end else begin
      st     <= nxt;
      sus_s1 <= link.suspended_flag_n;
      sus_s2 <= sus_s1;
    end
  end

  assign link.rd_n         = st.rd_n;
  assign link.wr_n         = st.wr_n;
  assign link.oe_n         = st.oe_n;
  assign link.flush_wake_n = st.flush_n;
  assign link.host_data_o  = st.dout;
  assign link.host_data_oe = st.dout_oe;
  assign rd_data           = st.rd_data;
  assign rd_valid          = st.rd_valid;
  assign wr_ready          = st.wr_ready;
  assign dev_suspended     = sus_s2;

endmodule : sfifo_host

// ---- bench/sfifo_monitor.sv ----
// Concurrent checks on the pins that join the FIFO device end and the external logic end.
// Assumes the device divider half period is four system clocks and one shared clk domain.
`timescale 1ns/10ps

module sfifo_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic interface_clock,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic oe_n,
  input wire logic flush_wake_n,
  input wire logic dev_data_oe,
  input wire logic host_data_oe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // The link clock keeps toggling every fourth system clock, with no gap.
  property p_link_clock;
    $changed(interface_clock) |=> $stable(interface_clock) [*3] ##1 $changed(interface_clock);
  endproperty
  a_link_clock: assert property (p_link_clock)
    else $error("link clock lost its rhythm");

  // Strobes move once per link period, so every change stands a whole period.
  property p_rd_period;
    $changed(rd_n) |=> $stable(rd_n) [*7];
  endproperty
  a_rd_period: assert property (p_rd_period)
    else $error("read strobe changed inside a link period");
  property p_wr_period;
    $changed(wr_n) |=> $stable(wr_n) [*7];
  endproperty
  a_wr_period: assert property (p_wr_period)
    else $error("write strobe changed inside a link period");

  // Output enable must lead the read strobe by one link period for the turn-around.
  property p_oe_lead;
    $fell(rd_n) |-> !oe_n && !$past(oe_n, 7);
  endproperty
  a_oe_lead: assert property (p_oe_lead)
    else $error("read strobe without output enable lead");

  // The device drives the bus only behind a low output enable.
  property p_oe_release;
    oe_n [*4] |-> !dev_data_oe;
  endproperty
  a_oe_release: assert property (p_oe_release)
    else $error("device drives bus with output enable high");
  property p_oe_cause;
    $rose(dev_data_oe) |-> !$past(oe_n, 2);
  endproperty
  a_oe_cause: assert property (p_oe_cause)
    else $error("device drive started without output enable");

  // A write strobe always carries the external logic's byte on the wires.
  property p_wr_drives;
    $fell(wr_n) |-> host_data_oe;
  endproperty
  a_wr_drives: assert property (p_wr_drives)
    else $error("write strobe without data driven");

  // The flush strobe lasts exactly one link period.
  property p_flush_strobe;
    $fell(flush_wake_n) |=> !flush_wake_n [*7] ##1 flush_wake_n;
  endproperty
  a_flush_strobe: assert property (p_flush_strobe)
    else $error("flush strobe length wrong");
endmodule : sfifo_monitor

// ---- bench/sync_parallel_fifo_port_tb_top.sv ----
// Self-checking bench: both FIFO port ends joined by the pin interface, USB side modelled here.
// Assumes the design files and sfifo_defines.svh are compiled first.
`timescale 1ns/10ps
`include "sfifo_defines.svh"

module sync_parallel_fifo_port_tb_top;
  import sfifo_pkg::*;
  logic  clk = 1'b0, rst = 1'b1, cfg_fifo_mode = 1'b0, mode_select = 1'b0, remote_wake_en = 1'b0;
  logic  usb_suspended = 1'b0, usb_configured = 1'b0, bulk_in_req = 1'b0, rx_valid = 1'b0;
  logic  tx_ready = 1'b1, rd_want = 1'b0, wr_valid = 1'b0, flush_req = 1'b0;
  byte_t rx_data = 8'h00, wr_data = 8'h00, tx_data, rd_data;
  logic  rx_ready, tx_valid, sync_active, chan_b_avail, resume_req, flush_pending;
  logic  rd_valid, wr_ready, dev_suspended;
  int    fail_count = 0, samples_checked = 0, cycles = 0, resumes = 0;
  byte_t rxq[$], txq[$], rdq[$];
  bit    take;

  sfifo_if sfifo_if_inst ();
  sfifo_device #(.HALF_CYCLES(4)) sfifo_device_inst (.clk(clk), .rst(rst), .link(sfifo_if_inst.dev_mp),
    .cfg_fifo_mode(cfg_fifo_mode), .mode_select(mode_select), .remote_wake_en(remote_wake_en),
    .usb_suspended(usb_suspended), .usb_configured(usb_configured), .bulk_in_req(bulk_in_req),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .sync_active(sync_active), .chan_b_avail(chan_b_avail),
    .resume_req(resume_req), .flush_pending(flush_pending));
  sfifo_host sfifo_host_inst (.clk(clk), .rst(rst), .link(sfifo_if_inst.host_mp), .rd_want(rd_want),
    .rd_data(rd_data), .rd_valid(rd_valid), .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .flush_req(flush_req), .dev_suspended(dev_suspended));
  sfifo_monitor sfifo_monitor_inst (.clk(clk), .rst(rst), .interface_clock(sfifo_if_inst.interface_clock),
    .rd_n(sfifo_if_inst.rd_n), .wr_n(sfifo_if_inst.wr_n), .oe_n(sfifo_if_inst.oe_n),
    .flush_wake_n(sfifo_if_inst.flush_wake_n), .dev_data_oe(sfifo_if_inst.dev_data_oe),
    .host_data_oe(sfifo_if_inst.host_data_oe));

  // System clock of 10 ns.
  always #5 clk = ~clk;

  // Sample at the falling edge, where every registered output has long settled.
  always @(negedge clk) begin
    take = rx_valid === 1'b1 && rx_ready === 1'b1;
    if (tx_valid === 1'b1) txq.push_back(tx_data);
    if (rd_valid === 1'b1) rdq.push_back(rd_data);
    if (resume_req === 1'b1) resumes++;
  end

  // Receive source shows its head byte; an empty source shows no stale byte.
  always @(posedge clk) begin
    #1;
    if (take) void'(rxq.pop_front());
    rx_valid = rxq.size() > 0;
    rx_data = rx_valid ? rxq[0] : 8'h00;
  end

  // A hang is cut short well after the longest expected run.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic chk(input bit ok, input string msg);
    samples_checked++;
    if (!ok) begin
      fail_count++;
      $display("ERROR at %0t: %s", $time, msg);
    end
  endtask : chk

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  // Holds the write request until the host has taken it; the caller drops wr_valid.
  task automatic send(input byte_t b);
    int n;
    wr_data = b;
    wr_valid = 1'b1;
    for (n = 0; n < 300 && wr_ready !== 1'b1; n++) tick(1);
    tick(1);
  endtask : send

  task automatic flush();
    flush_req = 1'b1;
    tick(1);
    flush_req = 1'b0;
    tick(60);
  endtask : flush

  // A mode command without the stored setting is refused; with it the second channel goes away.
  task automatic t_mode();
    chk(sfifo_if_inst.suspended_flag_n === 1'b1, "power flag low while unconfigured");
    usb_configured = 1'b1;
    rxq.push_back(8'h5a);
    mode_select = 1'b1;
    tick(1);
    mode_select = 1'b0;
    tick(40);
    chk(sfifo_if_inst.suspended_flag_n === 1'b0, "power flag high in normal operation");
    chk(sync_active === 1'b0 && chan_b_avail === 1'b1, "mode taken without setting");
    chk(sfifo_if_inst.rx_avail_n === 1'b1 && rdq.size() == 0, "read outside the mode");
    chk(sfifo_if_inst.fifo_data_bus === `IDLE_BYTE, "bus driven while idle");
    cfg_fifo_mode = 1'b1;
    mode_select = 1'b1;
    tick(1);
    mode_select = 1'b0;
    tick(2);
    chk(sync_active === 1'b1 && chan_b_avail === 1'b0, "mode not entered");
  endtask : t_mode

  // Back-to-back reads with boundary bytes, then the flag must return high when empty.
  task automatic t_read();
    byte_t exp[4] = '{8'h5a, 8'h00, 8'hff, 8'ha5};
    int i;
    tick(40);
    chk(sfifo_if_inst.rx_avail_n === 1'b0, "receive flag high with byte waiting");
    for (i = 1; i < 4; i++) rxq.push_back(exp[i]);
    rd_want = 1'b1;
    for (i = 0; i < 400 && rdq.size() < 4; i++) tick(1);
    rd_want = 1'b0;
    chk(rdq.size() == 4, "receive byte count wrong");
    for (i = 0; i < 4 && i < rdq.size(); i++) chk(rdq[i] === exp[i], "receive byte wrong");
    tick(40);
    chk(sfifo_if_inst.rx_avail_n === 1'b1, "receive flag low when empty");
  endtask : t_read

  // Streamed writes, then a stalled USB side must raise the space flag and hold the byte.
  task automatic t_write();
    byte_t exp[3] = '{8'h3c, 8'h81, 8'h00};
    int i;
    for (i = 0; i < 3; i++) send(exp[i]);
    wr_valid = 1'b0;
    for (i = 0; i < 300 && txq.size() < 3; i++) tick(1);
    chk(txq.size() == 3, "transmit byte count wrong");
    for (i = 0; i < 3 && i < txq.size(); i++) chk(txq[i] === exp[i], "transmit byte wrong");
    tx_ready = 1'b0;
    tick(20);
    send(8'h77);
    wr_valid = 1'b0;
    tick(100);
    chk(txq.size() == 3 && sfifo_if_inst.tx_space_n === 1'b1, "write taken while full");
    tx_ready = 1'b1;
    for (i = 0; i < 300 && txq.size() < 4; i++) tick(1);
    chk(txq.size() == 4 && txq[3] === 8'h77, "held byte lost");
  endtask : t_write

  // Flush in normal operation, then wake while suspended, refused without the wake setting.
  task automatic t_flush();
    flush();
    chk(flush_pending === 1'b1, "flush not pending");
    bulk_in_req = 1'b1;
    tick(1);
    bulk_in_req = 1'b0;
    tick(2);
    chk(flush_pending === 1'b0, "flush not cleared by bulk-IN");
    usb_suspended = 1'b1;
    tick(30);
    chk(sfifo_if_inst.suspended_flag_n === 1'b1 && dev_suspended === 1'b1, "suspend not shown");
    flush();
    chk(resumes == 0 && flush_pending === 1'b0, "wake honoured while disabled");
    remote_wake_en = 1'b1;
    flush();
    chk(resumes == 1, "no resume request");
    usb_suspended = 1'b0;
    tick(30);
    chk(sfifo_if_inst.suspended_flag_n === 1'b0, "power flag stuck high");
  endtask : t_flush

  // Reset for two cycles, then each scenario in turn.
  initial begin
    tick(2);
    rst = 1'b0;
    t_mode();
    t_read();
    t_write();
    t_flush();
    give_verdict();
  end
endmodule : sync_parallel_fifo_port_tb_top
